// *** lockstep_params.svh ***
// Constants for the dual processor lockstep controller
`ifndef LOCKSTEP_PARAMS_SVH
`define LOCKSTEP_PARAMS_SVH
`define LS_DATA_W      16
`define LS_ADDR_W      20
`define LS_CTRL_W      4
`define LS_BYTES       2
`define LS_TIME_DIV    8
`define LS_ROLE_RESET  3'h2
`endif

// *** lockstep_pkg.sv ***
// Types for the dual processor lockstep controller
`include "lockstep_params.svh"
package lockstep_pkg;
  typedef enum logic [2:0] {
    ST_MASTER,
    ST_STANDBY,
    ST_PASSIVE,
    ST_BACKUP,
    ST_FAULT
  } cpu_state_t;

  typedef struct packed {
    logic [`LS_ADDR_W-1:0] addr;
    logic [`LS_DATA_W-1:0] wdata;
    logic [`LS_CTRL_W-1:0] ctrl;
  } cpu_bus_t;

  typedef struct packed {
    logic [`LS_DATA_W-1:0] data;
    logic [`LS_BYTES-1:0]  par;
    logic                  valid;
  } rd_word_t;
endpackage

// *** dual_cpu_lockstep_control.sv ***
// Lockstep redundancy controller for a pair of identical processors
//
// Operation
// - On simultaneous start the first processor becomes master.
// - Second processor goes passive, backup on sync request with software loaded, then standby after memory update completes.
// - Only the master state drives process control.
// - Standby processor executes the master's instruction stream in lockstep.
// - Passive processor is decoupled; the pair runs asynchronously.
// - Backup copies master memory; fault marks a software-detected fault.
// - I/O modules get the master's signals, or the second processor's when neither is master.
// - Only the master's network interface is active on the plant bus.
// - Comparator checks all data and control of both processors in sync.
// - Buses coupled; single-channel input delivered identically to both.
// - During backup, master read data also written to the second processor.
// - In sync both issue identical addresses and controls each cycle.
// - Processor clocks come from the sync unit, not local oscillators.
// - Slow time clock passes the sync unit for same-cycle edges.
// - Sync unit aligns clock, data, interrupts and reports status.
// - Each processor sends its status/reset indication to its sync unit.
// - Byte parity checked on reads; error raises the parity fault.
// - Differing diagnostic-mode settings drop synchronous operation.
// - Diagnostic mode switches off key monitoring functions.
// - I/O comparator repeats the pair comparison at I/O level.
// - Start asynchronous; sync only after identical software loaded.
// - I/O comparator flags any address, data or control disagreement.
`timescale 1ns/10ps
`include "lockstep_params.svh"
module dual_cpu_lockstep_control
  import lockstep_pkg::*;
#(
  parameter int TIME_DIV = `LS_TIME_DIV
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_start_a,
  input  wire logic                  i_start_b,
  input  wire logic                  i_sw_loaded,
  input  wire logic                  i_sync_req,
  input  wire logic                  i_update_done,
  input  wire logic [1:0]            i_sw_fault,
  input  wire logic                  i_master_swap,
  input  wire logic                  i_disc_clear,
  input  wire logic [1:0]            i_cpu_status,
  input  wire logic [1:0]            i_diag_mode_switch,
  input  wire logic                  i_time_tick,
  input  wire logic [1:0]            i_irq,
  input  wire cpu_bus_t              i_bus_a,
  input  wire cpu_bus_t              i_bus_b,
  input  wire rd_word_t              i_mem_rd,
  input  wire logic [`LS_DATA_W-1:0] i_io_in,
  input  wire cpu_bus_t              i_io_bus_a,
  input  wire cpu_bus_t              i_io_bus_b,
  output logic                       o_proc_clk_fast,
  output logic                       o_proc_clk_slow,
  output logic [1:0]                 o_time_tick,
  output logic [1:0]                 o_irq,
  output logic [2:0]                 o_state_a,
  output logic [2:0]                 o_state_b,
  output logic [1:0]                 o_process_en,
  output logic [1:0]                 o_net_en,
  output cpu_bus_t                   o_io_bus,
  output logic [`LS_DATA_W-1:0]      o_in_a,
  output logic [`LS_DATA_W-1:0]      o_in_b,
  output logic                       o_copy_we,
  output logic [`LS_DATA_W-1:0]      o_copy_data,
  output logic [`LS_ADDR_W-1:0]      o_copy_addr,
  output logic                       o_parity_fault,
  output logic                       o_lockstep_err,
  output logic                       o_io_compare_err,
  output logic                       o_discrepancy,
  output logic                       o_in_sync,
  output logic [1:0]                 o_cpu_status_seen,
  output logic                       o_monitor_en
);

  initial begin
    if (TIME_DIV < 2) $error("TIME_DIV must be at least 2");
  end

  function automatic logic par_bad(input rd_word_t w);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < `LS_BYTES; i++) begin
      bad = bad | (^{w.data[i*8 +: 8], w.par[i]});
    end
    return bad;
  endfunction

  // ==========================================================
  // Input synchronisers for pin-level signals
  // ==========================================================
  logic [9:0] pin_s1_q;
  logic [9:0] pin_s2_q;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_s1_q <= 10'h000;
      pin_s2_q <= 10'h000;
    end else begin
      pin_s1_q <= {i_start_a, i_start_b, i_diag_mode_switch, i_time_tick,
                   i_irq, i_cpu_status, i_disc_clear};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic       start_a, start_b, tick, clr;
  logic [1:0] diag, irq, stat;
  assign {start_a, start_b, diag, tick, irq, stat, clr} = pin_s2_q;

  // ==========================================================
  // Processor clocks and slow time clock
  // ==========================================================
  logic [$clog2(TIME_DIV)-1:0] div_q;
  logic                        tick_q;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      div_q           <= '0;
      o_proc_clk_fast <= 1'b0;
      o_proc_clk_slow <= 1'b0;
    end else begin
      // Both processors share these; no local oscillator used
      o_proc_clk_fast <= ~o_proc_clk_fast;
      if (o_proc_clk_fast) begin
        o_proc_clk_slow <= ~o_proc_clk_slow;
      end
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_q      <= 1'b0;
      o_time_tick <= 2'b00;
      o_irq       <= 2'b00;
      o_cpu_status_seen <= 2'b00;
    end else begin
      tick_q      <= tick;
      o_time_tick <= {2{tick & ~tick_q}};
      // Either processor's interrupt reaches both in the same cycle
      o_irq       <= {2{|irq}};
      o_cpu_status_seen <= stat;
    end
  end

  // ==========================================================
  // Role state machines
  // ==========================================================
  cpu_state_t st_a_q, st_b_q;
  logic       diag_mismatch;
  logic       sync_q;
  assign diag_mismatch = diag[0] ^ diag[1];

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_a_q <= ST_PASSIVE;
      st_b_q <= ST_PASSIVE;
      sync_q <= 1'b0;
    end else begin
      if (i_sw_fault[0]) begin
        st_a_q <= ST_FAULT;
      end
      if (i_sw_fault[1]) begin
        st_b_q <= ST_FAULT;
      end
      if (diag_mismatch) begin
        sync_q <= 1'b0;
        if (st_a_q != ST_MASTER && st_a_q != ST_FAULT && !i_sw_fault[0]) begin
          st_a_q <= ST_PASSIVE;
        end
        if (st_b_q != ST_MASTER && st_b_q != ST_FAULT && !i_sw_fault[1]) begin
          st_b_q <= ST_PASSIVE;
        end
      end else if (!(|i_sw_fault)) begin
        case ({st_a_q, st_b_q})
          {ST_PASSIVE, ST_PASSIVE}: begin
            if (start_a && start_b) begin
              st_a_q <= ST_MASTER;
            end else if (start_a) begin
              st_a_q <= ST_MASTER;
            end else if (start_b) begin
              st_b_q <= ST_MASTER;
            end
          end
          {ST_MASTER, ST_PASSIVE}: begin
            if (i_sync_req && i_sw_loaded) begin
              st_b_q <= ST_BACKUP;
            end
          end
          {ST_PASSIVE, ST_MASTER}: begin
            if (i_sync_req && i_sw_loaded) begin
              st_a_q <= ST_BACKUP;
            end
          end
          {ST_MASTER, ST_BACKUP}: begin
            if (i_update_done) begin
              st_b_q <= ST_STANDBY;
              sync_q <= 1'b1;
            end
          end
          {ST_BACKUP, ST_MASTER}: begin
            if (i_update_done) begin
              st_a_q <= ST_STANDBY;
              sync_q <= 1'b1;
            end
          end
          {ST_MASTER, ST_STANDBY}, {ST_STANDBY, ST_MASTER}: begin
            if (i_master_swap) begin
              st_a_q <= st_b_q;
              st_b_q <= st_a_q;
            end
          end
          default: begin
            // Master survivor of a faulted pair keeps mastership; a standby survivor takes it
            if (st_a_q == ST_FAULT && st_b_q == ST_STANDBY) begin
              st_b_q <= ST_MASTER;
              sync_q <= 1'b0;
            end else if (st_b_q == ST_FAULT && st_a_q == ST_STANDBY) begin
              st_a_q <= ST_MASTER;
              sync_q <= 1'b0;
            end
          end
        endcase
      end
      if (|i_sw_fault) begin
        sync_q <= 1'b0;
        if (st_a_q == ST_STANDBY && i_sw_fault[1]) st_a_q <= ST_MASTER;
        if (st_b_q == ST_STANDBY && i_sw_fault[0]) st_b_q <= ST_MASTER;
      end
    end
  end

  // ==========================================================
  // Routing and comparison
  // ==========================================================
  logic      a_master, in_sync, mon;
  cpu_bus_t  master_bus;
  assign a_master   = (st_a_q == ST_MASTER);
  assign master_bus = a_master ? i_bus_a : i_bus_b;
  assign in_sync    = sync_q && ((st_a_q == ST_STANDBY) || (st_b_q == ST_STANDBY));
  // Service setting silences checks; keep off in normal operation
  assign mon        = ~(|diag);

  logic cpu_mis, io_mis;
  assign cpu_mis = in_sync && (i_bus_a != i_bus_b);
  assign io_mis  = in_sync && (i_io_bus_a != i_io_bus_b);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_state_a    <= `LS_ROLE_RESET;
      o_state_b    <= `LS_ROLE_RESET;
      o_process_en <= 2'b00;
      o_net_en     <= 2'b00;
      o_io_bus     <= '0;
      o_in_a       <= '0;
      o_in_b       <= '0;
      o_in_sync    <= 1'b0;
      o_monitor_en <= 1'b1;
    end else begin
      o_state_a    <= st_a_q;
      o_state_b    <= st_b_q;
      o_process_en <= {st_b_q == ST_MASTER, a_master};
      o_net_en     <= {st_b_q == ST_MASTER, a_master};
      o_io_bus     <= master_bus;
      o_in_a       <= i_io_in;
      o_in_b       <= i_io_in;
      o_in_sync    <= in_sync;
      o_monitor_en <= mon;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_lockstep_err   <= 1'b0;
      o_io_compare_err <= 1'b0;
      o_discrepancy    <= 1'b0;
    end else begin
      o_lockstep_err   <= cpu_mis && mon;
      o_io_compare_err <= io_mis && mon;
      // Set wins over a same-cycle clear
      if ((cpu_mis || io_mis) && mon) begin
        o_discrepancy <= 1'b1;
      end else if (clr) begin
        o_discrepancy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Backup copy and parity
  // ==========================================================
  logic copying;
  assign copying = (st_a_q == ST_BACKUP) || (st_b_q == ST_BACKUP);
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_copy_we      <= 1'b0;
      o_copy_data    <= '0;
      o_copy_addr    <= '0;
      o_parity_fault <= 1'b0;
    end else begin
      o_copy_we      <= copying && i_mem_rd.valid;
      o_copy_data    <= i_mem_rd.data;
      o_copy_addr    <= master_bus.addr;
      o_parity_fault <= i_mem_rd.valid && par_bad(i_mem_rd);
    end
  end

endmodule

// *** lockstep_asserts.sv ***
// Port-level assertion checker for the lockstep controller
`timescale 1ns/10ps
`include "lockstep_params.svh"
module lockstep_asserts
  import lockstep_pkg::*;
(
  input wire logic                  i_ref_clk,
  input wire logic                  i_reset,
  input wire logic                  i_disc_clear,
  input wire logic [1:0]            i_diag_mode_switch,
  input wire cpu_bus_t              i_bus_a,
  input wire cpu_bus_t              i_bus_b,
  input wire rd_word_t              i_mem_rd,
  input wire cpu_bus_t              i_io_bus_a,
  input wire cpu_bus_t              i_io_bus_b,
  input wire logic [1:0]            o_irq,
  input wire logic [1:0]            o_time_tick,
  input wire logic [2:0]            o_state_a,
  input wire logic [2:0]            o_state_b,
  input wire logic [1:0]            o_process_en,
  input wire logic [1:0]            o_net_en,
  input wire cpu_bus_t              o_io_bus,
  input wire logic                  o_copy_we,
  input wire logic [`LS_DATA_W-1:0] o_copy_data,
  input wire logic                  o_parity_fault,
  input wire logic                  o_lockstep_err,
  input wire logic                  o_io_compare_err,
  input wire logic                  o_discrepancy,
  input wire logic                  o_in_sync,
  input wire logic                  o_monitor_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Each byte with its parity bit must xor to zero
  logic bad_rd;
  assign bad_rd = i_mem_rd.valid & ((^{i_mem_rd.data[7:0], i_mem_rd.par[0]})
                                  | (^{i_mem_rd.data[15:8], i_mem_rd.par[1]}));
  // ==========================================
  // Properties
  property p_one_master; o_process_en != 2'h3 && o_net_en != 2'h3; endproperty
  a_one_master: assert property (p_one_master) else $error("both sides enabled");
  property p_en_state; !o_process_en[0] || o_state_a == 3'h0; endproperty
  a_en_state: assert property (p_en_state) else $error("enable without master");
  property p_io_master; o_state_a == 3'h0 ##1 o_state_a == 3'h0 |-> o_io_bus == $past(i_bus_a);
  endproperty
  a_io_master: assert property (p_io_master) else $error("io bus not from master");
  property p_copy; i_mem_rd.valid ##1 o_state_b == 3'h3 |->
    o_copy_we && o_copy_data == $past(i_mem_rd.data); endproperty
  a_copy: assert property (p_copy) else $error("backup copy missing");
  property p_parity; bad_rd && o_monitor_en |=> o_parity_fault; endproperty
  a_parity: assert property (p_parity) else $error("parity fault missing");
  property p_lockstep; o_in_sync && o_monitor_en && i_bus_a != i_bus_b
    ##1 o_in_sync && o_monitor_en |-> o_lockstep_err; endproperty
  a_lockstep: assert property (p_lockstep) else $error("bus mismatch unflagged");
  property p_io_cmp; o_in_sync && o_monitor_en && i_io_bus_a != i_io_bus_b
    ##1 o_in_sync && o_monitor_en |-> o_io_compare_err; endproperty
  a_io_cmp: assert property (p_io_cmp) else $error("io mismatch unflagged");
  property p_sticky; o_discrepancy && !(i_disc_clear || $past(i_disc_clear)
    || $past(i_disc_clear, 2) || $past(i_disc_clear, 3)) |=> o_discrepancy; endproperty
  a_sticky: assert property (p_sticky) else $error("discrepancy lost");
  property p_monitor; (i_diag_mode_switch != 2'h0) [*3] |=> !o_monitor_en; endproperty
  a_monitor: assert property (p_monitor) else $error("monitor left on");
  property p_pairs; o_irq[0] == o_irq[1] && o_time_tick[0] == o_time_tick[1]; endproperty
  a_pairs: assert property (p_pairs) else $error("sides see different events");
  c_copy: cover property (o_copy_we);
  c_mismatch: cover property (o_lockstep_err);
  c_parity: cover property (o_parity_fault);
endmodule

// *** cpu_pair_model.sv ***
// Behavioural twin processor pair: processor, io and memory read buses
`timescale 1ns/10ps
`include "lockstep_params.svh"
module cpu_pair_model
  import lockstep_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic [`LS_DATA_W-1:0] i_word,
  input  wire logic                  i_skew,
  input  wire logic                  i_io_skew,
  input  wire logic                  i_rd_en,
  input  wire logic                  i_bad_par,
  output cpu_bus_t                   o_bus_a,
  output cpu_bus_t                   o_bus_b,
  output cpu_bus_t                   o_io_a,
  output cpu_bus_t                   o_io_b,
  output rd_word_t                   o_rd
);
  cpu_bus_t b;
  assign b = '{addr: {4'h0, i_word}, wdata: ~i_word, ctrl: i_word[3:0]};
  initial {o_bus_a, o_bus_b, o_io_a, o_io_b, o_rd} = '0;
  // Skew only where a scenario asks for a diverging twin
  always @(posedge i_clk) begin
    o_bus_a <= #1 b;
    o_bus_b <= #1 i_skew ? ~b : b;
    o_io_a <= #1 b;
    o_io_b <= #1 i_io_skew ? ~b : b;
    o_rd <= #1 '{data: i_word, par: {^i_word[15:8], ^i_word[7:0] ^ i_bad_par}, valid: i_rd_en};
  end
endmodule

// *** dual_cpu_lockstep_control_bench.sv ***
// Self-checking bench for the lockstep controller
`timescale 1ns/10ps
module dual_cpu_lockstep_control_bench
  import lockstep_pkg::*;
;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_start_a = 1'b0, i_start_b = 1'b0;
  logic i_sw_loaded = 1'b0, i_sync_req = 1'b0, i_update_done = 1'b0, i_disc_clear = 1'b0;
  logic i_time_tick = 1'b0, skew = 1'b0, io_skew = 1'b0, rd_en = 1'b0, bad = 1'b0;
  logic [1:0] i_sw_fault = 2'h0, i_cpu_status = 2'h0, i_diag_mode_switch = 2'h0, i_irq = 2'h0;
  logic [15:0] i_io_in = 16'h0, word = 16'h0, seed = 16'hFFF6, o_in_a, o_in_b, o_copy_data;
  logic [2:0] o_state_a, o_state_b;
  logic [1:0] o_process_en, o_net_en, o_irq;
  logic o_copy_we, o_parity_fault, o_lockstep_err, o_io_compare_err, o_discrepancy;
  logic o_in_sync, o_monitor_en, o_proc_clk_fast, o_proc_clk_slow, pf, ps, i_master_swap = 1'b0;
  logic [1:0] o_time_tick, o_cpu_status_seen;
  logic [19:0] o_copy_addr;
  cpu_bus_t i_bus_a, i_bus_b, i_io_bus_a, i_io_bus_b, o_io_bus;
  rd_word_t i_mem_rd;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  dual_cpu_lockstep_control i_dual_cpu_lockstep_control (
    .i_ref_clk, .i_reset, .i_start_a, .i_start_b, .i_sw_loaded, .i_sync_req, .i_update_done,
    .i_sw_fault, .i_master_swap, .i_disc_clear, .i_cpu_status, .i_diag_mode_switch,
    .i_time_tick, .i_irq, .i_bus_a, .i_bus_b, .i_mem_rd, .i_io_in, .i_io_bus_a, .i_io_bus_b,
    .o_proc_clk_fast, .o_proc_clk_slow, .o_time_tick, .o_irq, .o_state_a, .o_state_b,
    .o_process_en, .o_net_en, .o_io_bus, .o_in_a, .o_in_b, .o_copy_we, .o_copy_data,
    .o_copy_addr, .o_parity_fault, .o_lockstep_err, .o_io_compare_err, .o_discrepancy,
    .o_in_sync, .o_cpu_status_seen, .o_monitor_en);
  cpu_pair_model i_cpu_pair_model (.i_clk(i_ref_clk), .i_word(word), .i_skew(skew),
    .i_io_skew(io_skew), .i_rd_en(rd_en), .i_bad_par(bad), .o_bus_a(i_bus_a),
    .o_bus_b(i_bus_b), .o_io_a(i_io_bus_a), .o_io_b(i_io_bus_b), .o_rd(i_mem_rd));
  // ==========================================
  // Clock, timeout and helpers
  initial forever #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic par_bad(input rd_word_t r);
    return r.valid & ((^{r.data[7:0], r.par[0]}) | (^{r.data[15:8], r.par[1]}));
  endfunction
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // Random traffic; cp marks backup, where every read is copied
  task automatic traffic(input int n, input logic cp);
    cpu_bus_t eb;
    rd_word_t er;
    logic [15:0] ei;
    repeat (n) begin
      seed = lfsr_next(seed);
      {word, i_io_in, i_cpu_status, i_irq, i_time_tick} = {seed, ~seed, seed[1:0], seed[6:5], seed[7]};
      rd_en = seed[4];
      bad = seed[9] & seed[3];
      #1;
      {eb, er, ei} = {i_bus_a, i_mem_rd, i_io_in};
      step();
      chk(o_io_bus === eb, "io bus not master");
      chk(o_in_a === ei && o_in_b === ei, "input fan out");
      chk(o_parity_fault === par_bad(er), "parity flag");
      chk(o_copy_we === (cp & er.valid) && (!o_copy_we || o_copy_data === er.data), "copy");
      chk(!o_copy_we || o_copy_addr === eb.addr, "copy address");
    end
    {rd_en, bad} = 2'h0;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    step(16);
    chk(o_state_a === ST_PASSIVE && o_process_en === 2'h0 && o_monitor_en === 1'b1, "reset");
    i_reset = 1'b0;
    {i_start_a, i_start_b} = 2'h3;
    step(6);
    chk(o_state_a === ST_MASTER && o_state_b === ST_PASSIVE, "start roles");
    chk(o_process_en === 2'h1 && o_net_en === 2'h1, "master enables");
    skew = 1'b1; // Passive twin runs its own stream
    traffic(30, 1'b0);
    skew = 1'b0;
    i_sync_req = 1'b1;
    step(8);
    chk(o_state_b === ST_PASSIVE, "sync before load");
    i_sw_loaded = 1'b1;
    for (int k = 0; k < 20 && o_state_b !== ST_BACKUP; k++) step();
    chk(o_state_b === ST_BACKUP, "backup entry");
    traffic(40, 1'b1);
    i_update_done = 1'b1;
    for (int k = 0; k < 20 && o_in_sync !== 1'b1; k++) step();
    chk(o_state_b === ST_STANDBY && o_in_sync === 1'b1, "standby");
    i_update_done = 1'b0;
    traffic(30, 1'b0);
    skew = 1'b1;
    step(3);
    chk(o_lockstep_err === 1'b1 && o_discrepancy === 1'b1, "bus mismatch");
    skew = 1'b0;
    io_skew = 1'b1;
    step(3);
    chk(o_io_compare_err === 1'b1 && o_lockstep_err === 1'b0, "io mismatch");
    io_skew = 1'b0;
    step(4);
    chk(o_discrepancy === 1'b1, "discrepancy held");
    i_disc_clear = 1'b1;
    step();
    i_disc_clear = 1'b0;
    step(5);
    chk(o_discrepancy === 1'b0, "discrepancy clear");
    i_irq = 2'h2;
    i_cpu_status = 2'h1;
    i_time_tick = 1'b0;
    step(4);
    chk(o_irq === 2'h3, "irq to both");
    chk(o_cpu_status_seen === 2'h1 && o_time_tick === 2'h0, "status seen");
    i_time_tick = 1'b1;
    step(3);
    chk(o_time_tick === 2'h3, "time tick edge");
    step();
    chk(o_time_tick === 2'h0, "time tick pulse");
    pf = o_proc_clk_fast;
    ps = o_proc_clk_slow;
    step();
    chk({pf, o_proc_clk_fast} === 2'h1 || {pf, o_proc_clk_fast} === 2'h2, "fast clock");
    step();
    chk(o_proc_clk_fast === pf && ({ps, o_proc_clk_slow} === 2'h1 || {ps, o_proc_clk_slow} === 2'h2), "slow clock");
    // Standby takes over mastership in one step
    i_master_swap = 1'b1;
    step();
    i_master_swap = 1'b0;
    step();
    chk(o_state_a === ST_STANDBY && o_state_b === ST_MASTER && o_in_sync === 1'b1, "swap");
    chk(o_process_en === 2'h2 && o_net_en === 2'h2 && o_io_bus === i_bus_b, "new master");
    i_diag_mode_switch = 2'h1;
    step(6);
    chk(o_monitor_en === 1'b0 && o_in_sync === 1'b0, "diag mismatch");
    chk(o_state_a === ST_PASSIVE && o_state_b === ST_MASTER, "standby decoupled");
    i_sw_fault = 2'h2;
    step();
    i_sw_fault = 2'h0;
    step();
    chk(o_state_b === ST_FAULT && o_process_en === 2'h0 && o_net_en === 2'h0, "fault");
    tally_and_finish();
  end
endmodule
bind dual_cpu_lockstep_control lockstep_asserts i_lockstep_asserts (.*);
